// *** logic/bbm_master.sv ***
// master end: issues write and read bursts on the burst bus
`include "bbm_regs.svh"
// Behaviour
// - fabric locks target for whole burst
// - idle cycles inside bursts are tolerated
// - burst opens with address and word count
// - responder derives later burst addresses
// - both read and write bursts supported
// - exactly b transfers, never abandoned
// - new read burst before old returns
// - write burst taken when stall low
// - address and count held during write
// - write strobe may drop to pause
// - stalled write holds mask, data, address
// - read address phase ends stall low
// - read words marked by valid strobe
// - responder may pause read data
// - master always accepts read words
// - responder returns exactly count words
// - read word registered every valid cycle
// - controls held through address phase
// - flush cancels pending reads
// - read words return in issue order
module bbm_master (
  // system
  input  wire logic                clock,
  input  wire logic                rst_n,
  // bus
  bbm_if.master                    bus,
  // command
  input  wire logic                cmdValid,
  input  wire logic                cmdWrite,
  input  wire bbm_pkg::bbm_addr_t  cmdAddr,
  input  wire bbm_pkg::bbm_cnt_t   cmdCount,
  input  wire bbm_pkg::bbm_be_t    cmdBe,
  output logic                     cmdReady,
  // write words
  input  wire logic                wrValid,
  input  wire bbm_pkg::bbm_data_t  wrData,
  output logic                     wrTaken,
  // read words, flush and write done
  input  wire logic                flushReq,
  output logic                     rdValid,
  output bbm_pkg::bbm_data_t       rdData,
  output bbm_pkg::bbm_cnt_t        rdPending,
  output logic                     wrDone
);
  typedef struct packed {
    // burst control
    bbm_pkg::bbm_mstate_t st;
    bbm_pkg::bbm_addr_t   addr;
    bbm_pkg::bbm_cnt_t    cnt;
    bbm_pkg::bbm_cnt_t    left;
    logic                 rd;
    logic                 wr;
    bbm_pkg::bbm_data_t   wdata;
    bbm_pkg::bbm_be_t     be;
    logic                 flush;
    // user side pulses and levels
    logic                 ready;
    logic                 taken;
    logic                 done;
    // returned read words
    logic                 rdv;
    bbm_pkg::bbm_data_t   rdata;
    bbm_pkg::bbm_cnt_t    pend;
  } bbm_ms_t;

  bbm_ms_t s_q, s_d;
  logic    accept;
  logic    gotWord;
  logic    lastBeat;
  logic    loadWord;

  // a zero count would be an empty burst, which the bus cannot express
  function automatic bbm_pkg::bbm_cnt_t clampCount(input bbm_pkg::bbm_cnt_t c);
    if (c == 7'h00) return 7'h01;
    if (c > `BBM_MAX_BURST) return `BBM_MAX_BURST;
    return c;
  endfunction

  // owed read words: less one returned word, plus a newly accepted burst
  function automatic bbm_pkg::bbm_cnt_t owedNext(input bbm_pkg::bbm_cnt_t owed,
      input logic got, input logic add, input bbm_pkg::bbm_cnt_t len);
    bbm_pkg::bbm_cnt_t r;
    r = owed;
    if (got && r != 7'h00) begin
      r = r - 7'h01;
    end
    if (add) begin
      r = r + len;
    end
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    accept = (s_q.rd || s_q.wr) && !bus.waitRequest;
    gotWord = bus.readDataValid;
    lastBeat = accept && s_q.wr && (s_q.left == 7'h01);
    loadWord = 1'b0;
    // one-cycle pulses fall back every cycle
    s_d.taken = 1'b0;
    s_d.done  = 1'b0;
    s_d.flush = 1'b0;
    s_d.ready = 1'b0;
    // no back-pressure on returned words: every one is taken
    s_d.rdv = gotWord;
    if (gotWord) begin
      s_d.rdata = bus.readData;
    end
    s_d.pend = owedNext(s_q.pend, gotWord, 1'b0, s_q.cnt);
    case (s_q.st)
      // waiting for a command or a flush request
      bbm_pkg::MsIdle: begin
        if (cmdValid && s_q.ready) begin
          s_d.addr = cmdAddr;
          s_d.cnt  = clampCount(cmdCount);
          s_d.left = clampCount(cmdCount);
          s_d.be   = cmdBe;
          if (cmdWrite) begin
            s_d.st = bbm_pkg::MsWrAddr;
            s_d.wr = wrValid;
            s_d.wdata = wrData;
            s_d.taken = wrValid;
          end else begin
            s_d.st = bbm_pkg::MsRdAddr;
            s_d.rd = 1'b1;
          end
        end else begin
          // flush only from idle, so no read address is ever open with it
          s_d.ready = !flushReq;
          s_d.flush = flushReq;
        end
      end
      // write burst: address and count stay put; only data and strobe move
      bbm_pkg::MsWrAddr, bbm_pkg::MsWrData: begin
        if (accept) begin
          s_d.left = s_q.left - 7'h01;
          s_d.wr   = 1'b0;
          s_d.st   = bbm_pkg::MsWrData;
        end
        if (lastBeat) begin
          s_d.st    = bbm_pkg::MsIdle;
          s_d.done  = 1'b1;
          s_d.ready = 1'b1;
        end
        // a word just taken is still on offer for a cycle; never take it twice
        loadWord = (accept || !s_q.wr) && !lastBeat && wrValid && !s_q.taken;
        if (loadWord) begin
          s_d.wr = 1'b1;
          s_d.wdata = wrData;
          s_d.taken = 1'b1;
        end
      end
      // read address phase: held until the responder lets it through
      bbm_pkg::MsRdAddr: begin
        if (accept) begin
          s_d.rd = 1'b0;
          s_d.st = bbm_pkg::MsIdle;
          s_d.ready = 1'b1;
          s_d.pend = owedNext(s_q.pend, gotWord, 1'b1, s_q.cnt);
        end
      end
      default: begin
        s_d.st = bbm_pkg::MsIdle;
      end
    endcase
    // words still on the way are dropped by the responder
    if (s_q.flush) begin
      s_d.pend = 7'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: bbm_pkg::MsIdle, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // bus side
  assign bus.address    = s_q.addr;
  assign bus.burstCount = s_q.cnt;
  assign bus.read       = s_q.rd;
  assign bus.write      = s_q.wr;
  assign bus.writeData  = s_q.wdata;
  assign bus.byteEnable = s_q.be;
  assign bus.flush      = s_q.flush;

  // user side
  assign cmdReady       = s_q.ready;
  assign wrTaken        = s_q.taken;
  assign wrDone         = s_q.done;
  assign rdValid        = s_q.rdv;
  assign rdData         = s_q.rdata;
  assign rdPending      = s_q.pend;
endmodule

// *** logic/bbm_regs.svh ***
// constants for the burst bus master and its responder end
`ifndef BBM_REGS_SVH
`define BBM_REGS_SVH
`define BBM_ADDR_W    32
`define BBM_DATA_W    32
`define BBM_BE_W      4
`define BBM_CNT_W     7
`define BBM_MAX_BURST 7'h40
`define BBM_MEM_WORDS 64
`define BBM_MEM_AW    6
`define BBM_RDQ_DEPTH 4
`define BBM_RDQ_AW    2
`endif

// *** logic/bbm_pkg.sv ***
// types shared by both ends of the burst bus
`include "bbm_regs.svh"
package bbm_pkg;
  typedef logic [`BBM_ADDR_W-1:0] bbm_addr_t;
  typedef logic [`BBM_DATA_W-1:0] bbm_data_t;
  typedef logic [`BBM_BE_W-1:0]   bbm_be_t;
  typedef logic [`BBM_CNT_W-1:0]  bbm_cnt_t;
  typedef enum logic [1:0] {MsIdle, MsWrAddr, MsWrData, MsRdAddr} bbm_mstate_t;
  typedef enum logic [1:0] {RsIdle, RsWrite} bbm_rstate_t;
endpackage

// *** logic/bbm_if.sv ***
// burst bus between master and responder
`include "bbm_regs.svh"
interface bbm_if;
  logic [`BBM_ADDR_W-1:0] address;
  logic [`BBM_CNT_W-1:0]  burstCount;
  logic                   read;
  logic                   write;
  logic [`BBM_DATA_W-1:0] writeData;
  logic [`BBM_BE_W-1:0]   byteEnable;
  logic                   flush;
  logic                   waitRequest;
  logic [`BBM_DATA_W-1:0] readData;
  logic                   readDataValid;
  modport master (
    output address, burstCount, read, write, writeData, byteEnable, flush,
    input  waitRequest, readData, readDataValid
  );
  modport responder (
    input  address, burstCount, read, write, writeData, byteEnable, flush,
    output waitRequest, readData, readDataValid
  );
endinterface

// *** logic/bbm_responder.sv ***
// responder end: small word memory answering write and read bursts
`include "bbm_regs.svh"
module bbm_responder (
  // system
  input  wire logic clock,
  input  wire logic rst_n,
  // bus
  bbm_if.responder  bus,
  // user side
  input  wire logic stallIn,
  input  wire logic holdRead,
  output logic      busy
);
  typedef struct packed {
    bbm_pkg::bbm_rstate_t    st;
    logic [`BBM_MEM_AW-1:0]  wAddr;
    bbm_pkg::bbm_cnt_t       wLeft;
    logic [`BBM_MEM_AW-1:0]  rAddr;
    bbm_pkg::bbm_cnt_t       rLeft;
    logic [`BBM_RDQ_AW:0]    qCnt;
    logic [`BBM_RDQ_AW-1:0]  qRd;
    logic [`BBM_RDQ_AW-1:0]  qWr;
    logic                    wait_;
    logic                    rdv;
    bbm_pkg::bbm_data_t      rdata;
    logic                    busy;
  } bbm_rs_t;

  bbm_pkg::bbm_data_t     mem [`BBM_MEM_WORDS];
  logic [`BBM_MEM_AW-1:0] qAddr [`BBM_RDQ_DEPTH];
  bbm_pkg::bbm_cnt_t      qLen  [`BBM_RDQ_DEPTH];
  bbm_rs_t s_q, s_d;
  logic memWe;
  logic qPush;

  function automatic bbm_pkg::bbm_data_t merge(input bbm_pkg::bbm_data_t o,
      input bbm_pkg::bbm_data_t n, input bbm_pkg::bbm_be_t be);
    bbm_pkg::bbm_data_t r;
    r = o;
    for (int i = 0; i < `BBM_BE_W; i++) begin
      if (be[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    memWe = 1'b0;
    qPush = 1'b0;
    s_d.rdv = 1'b0;
    case (s_q.st)
      bbm_pkg::RsIdle: begin
        if (!s_q.wait_ && bus.write) begin
          memWe = 1'b1;
          s_d.wAddr = bus.address[`BBM_MEM_AW+1:2] + 1'b1;
          s_d.wLeft = bus.burstCount - 1'b1;
          if (bus.burstCount > 7'h01) s_d.st = bbm_pkg::RsWrite;
        end else if (!s_q.wait_ && bus.read) begin
          qPush = 1'b1;
        end
      end
      bbm_pkg::RsWrite: begin
        // locked to this master until the burst is spent
        if (!s_q.wait_ && bus.write) begin
          memWe = 1'b1;
          s_d.wAddr = s_q.wAddr + 1'b1;
          s_d.wLeft = s_q.wLeft - 1'b1;
          if (s_q.wLeft == 7'h01) s_d.st = bbm_pkg::RsIdle;
        end
      end
      default: s_d.st = bbm_pkg::RsIdle;
    endcase
    if (qPush) begin
      s_d.qWr = s_q.qWr + 1'b1;
      s_d.qCnt = s_d.qCnt + 1'b1;
    end
    // deliver read words in issue order, pausing freely
    if (s_q.rLeft != 7'h00 && !holdRead) begin
      s_d.rdv = 1'b1;
      s_d.rdata = mem[s_q.rAddr];
      s_d.rAddr = s_q.rAddr + 1'b1;
      s_d.rLeft = s_q.rLeft - 1'b1;
    end else if (s_q.rLeft == 7'h00 && s_q.qCnt != 3'h0) begin
      s_d.rAddr = qAddr[s_q.qRd];
      s_d.rLeft = qLen[s_q.qRd];
      s_d.qRd = s_q.qRd + 1'b1;
      s_d.qCnt = s_d.qCnt - 1'b1;
    end
    if (bus.flush) begin
      s_d.rLeft = 7'h00;
      s_d.rdv = 1'b0;
      s_d.qRd = s_q.qWr;
      s_d.qCnt = qPush ? 3'h1 : 3'h0;
    end
    s_d.busy = (s_d.st != bbm_pkg::RsIdle) || s_d.rLeft != 7'h00 || s_d.qCnt != 3'h0;
    // stall ahead of a full queue: an open read is taken the moment stall is low
    s_d.wait_ = stallIn || (s_d.qCnt == 3'(`BBM_RDQ_DEPTH));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: bbm_pkg::RsIdle, wait_: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock) begin
    if (memWe) begin
      mem[s_q.st == bbm_pkg::RsIdle ? bus.address[`BBM_MEM_AW+1:2] : s_q.wAddr] <=
        merge(mem[s_q.st == bbm_pkg::RsIdle ? bus.address[`BBM_MEM_AW+1:2] : s_q.wAddr],
              bus.writeData, bus.byteEnable);
    end
    if (qPush) begin
      qAddr[s_q.qWr] <= bus.address[`BBM_MEM_AW+1:2];
      qLen[s_q.qWr]  <= bus.burstCount;
    end
  end

  assign bus.waitRequest   = s_q.wait_;
  assign bus.readDataValid = s_q.rdv;
  assign bus.readData      = s_q.rdata;
  assign busy              = s_q.busy;
endmodule

// *** bench/bbm_monitor.sv ***
// assertion checker watching the burst bus between the two ends
`include "bbm_regs.svh"
module bbm_monitor (
  // system
  input wire logic                   clock,
  input wire logic                   rst_n,
  // master side
  input wire logic [`BBM_ADDR_W-1:0] address,
  input wire logic [`BBM_CNT_W-1:0]  burstCount,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [`BBM_DATA_W-1:0] writeData,
  input wire logic [`BBM_BE_W-1:0]   byteEnable,
  input wire logic                   flush,
  // responder side
  input wire logic                   waitRequest,
  input wire logic [`BBM_DATA_W-1:0] readData,
  input wire logic                   readDataValid
);
  logic [6:0] wrLeft_q;
  logic [8:0] owed_q;
  wire        beat = write && !waitRequest;
  wire        rdAcc = read && !waitRequest;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // words still owed, so a stray valid can be caught
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrLeft_q <= 7'h00;
      owed_q <= 9'h000;
    end else begin
      if (beat) wrLeft_q <= (wrLeft_q == 7'h00) ? burstCount - 7'h01 : wrLeft_q - 7'h01;
      owed_q <= (flush ? 9'h000 : owed_q - 9'(readDataValid)) + (rdAcc ? 9'(burstCount) : 9'h000);
    end
  end
  a_wr_stall_hold: assert property (write && waitRequest |=> write && $stable(address)
    && $stable(writeData) && $stable(byteEnable)) else $error("write moved while stalled");
  a_rd_stall_hold: assert property (read && waitRequest |=> read && $stable(address)
    && $stable(burstCount) && $stable(byteEnable)) else $error("read moved while stalled");
  a_burst_hold: assert property (wrLeft_q != 7'h00 |-> $stable(address)
    && $stable(burstCount)) else $error("address or count moved in write burst");
  a_no_abandon: assert property (wrLeft_q != 7'h00 |-> !read)
    else $error("read started inside write burst");
  a_count_legal: assert property (read || write |-> burstCount != 7'h00
    && burstCount <= 7'h40) else $error("bad burst length");
  a_valid_owed: assert property (readDataValid |-> owed_q != 9'h000)
    else $error("read word with none owed");
  a_flush_cancel: assert property (flush && !read |=> !readDataValid)
    else $error("read word after flush");
  a_rw_apart: assert property (!(read && write))
    else $error("read and write together");
  c_wr_pause: cover property (wrLeft_q != 7'h00 && !write);
  c_rd_stall: cover property (read && waitRequest);
  c_flush: cover property (flush);
endmodule

// *** bench/burst_bus_master_tb_top.sv ***
// self-checking bench joining master and responder over the burst bus
`include "bbm_regs.svh"
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module burst_bus_master_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 0, rst_n = 0, cmdValid = 0, cmdWrite = 0, wrValid = 0;
  logic               flushReq = 0, stallIn = 0, holdRead = 0, noise = 0;
  logic               cmdReady, wrTaken, rdValid, wrDone, busy;
  bbm_pkg::bbm_addr_t cmdAddr = '0;
  bbm_pkg::bbm_cnt_t  cmdCount = '0, rdPending;
  bbm_pkg::bbm_be_t   cmdBe = '0;
  bbm_pkg::bbm_data_t wrData = '0, rdData, expW, mem[64], expQ[$];
  int                 fails = 0, nChecks = 0, cycles = 0, a, n;
  bbm_if bus();
  bbm_master i_bbm_master (.clock(clock), .rst_n(rst_n), .bus(bus), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdCount(cmdCount), .cmdBe(cmdBe),
    .cmdReady(cmdReady), .wrValid(wrValid), .wrData(wrData), .wrTaken(wrTaken),
    .flushReq(flushReq), .rdValid(rdValid), .rdData(rdData), .rdPending(rdPending),
    .wrDone(wrDone));
  bbm_responder i_bbm_responder (.clock(clock), .rst_n(rst_n), .bus(bus), .stallIn(stallIn),
    .holdRead(holdRead), .busy(busy));
  bbm_monitor i_bbm_monitor (.clock(clock), .rst_n(rst_n), .address(bus.address),
    .burstCount(bus.burstCount), .read(bus.read), .write(bus.write),
    .writeData(bus.writeData), .byteEnable(bus.byteEnable), .flush(bus.flush),
    .waitRequest(bus.waitRequest), .readData(bus.readData),
    .readDataValid(bus.readDataValid));
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      giveVerdict();
    end
  end
  // result watcher: one note off the queue per returned word
  always @(negedge clock) begin
    if (noise) begin
      stallIn <= ($urandom % 3) == 0;
      holdRead <= ($urandom % 3) == 0;
    end
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) `CHK("stray rdData", 1'b0, 1'b1)
      else begin
        expW = expQ.pop_front();
        `CHK("rdData", expW, rdData)
      end
    end
  end
  task automatic cmd(input logic w, input int ad, input int cnt, input bbm_pkg::bbm_be_t be);
    do @(negedge clock); while (cmdReady !== 1'b1);
    cmdValid = 1;
    cmdWrite = w;
    cmdAddr = bbm_pkg::bbm_addr_t'(ad * 4);
    cmdCount = bbm_pkg::bbm_cnt_t'(cnt);
    cmdBe = be;
    @(negedge clock);
    cmdValid = 0;
  endtask
  task automatic wrBurst(input int ad, input int cnt, input bbm_pkg::bbm_be_t be);
    bbm_pkg::bbm_data_t d, m;
    int gap;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    cmd(1, ad, cnt, be);
    for (int i = 0; i < cnt; i++) begin
      d = $urandom;
      gap = $urandom % 3;
      mem[ad + i] = (mem[ad + i] & ~m) | (d & m);
      if (gap > 0) begin
        wrValid = 0;
        repeat (gap) @(negedge clock);
      end
      wrValid = 1;
      wrData = d;
      do @(negedge clock); while (wrTaken !== 1'b1);
    end
    wrValid = 0;
    for (int k = 0; k < 60 && wrDone !== 1'b1; k++) @(negedge clock);
    `CHK("wrDone", 1'b1, wrDone)
  endtask
  task automatic rdBurst(input int ad, input int cnt);
    for (int i = 0; i < cnt; i++) expQ.push_back(mem[ad + i]);
    cmd(0, ad, cnt, 4'hf);
  endtask
  task automatic drain(input int t);
    for (int k = 0; k < 600 && expQ.size() != 0; k++) @(negedge clock);
    `CHK("words left", 0, expQ.size())
    $display("test %0d done", t);
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(4245));
    repeat (12) @(negedge clock);
    rst_n = 1;
    wrBurst(0, 64, 4'hf);
    rdBurst(0, 64);
    drain(1);
    noise = 1;
    for (int t = 0; t < 6; t++) begin
      a = $urandom % 48;
      n = 1 + $urandom % 16;
      // reads still in flight must not see the new words
      while (expQ.size() != 0) @(negedge clock);
      wrBurst(a, n, bbm_pkg::bbm_be_t'(1 + $urandom % 15));
      rdBurst(a, n);
    end
    drain(2);
    rdBurst(0, 8);
    rdBurst(8, 8);
    rdBurst(16, 4);
    drain(3);
    noise = 0;
    repeat (2) @(negedge clock);
    stallIn = 0;
    holdRead = 1;
    cmd(0, 0, 4, 4'hf);
    do @(negedge clock); while (cmdReady !== 1'b1);
    `CHK("rdPending", 7'h04, rdPending)
    flushReq = 1;
    @(negedge clock);
    flushReq = 0;
    repeat (4) @(negedge clock);
    `CHK("rdPending", 7'h00, rdPending)
    holdRead = 0;
    repeat (20) @(negedge clock);
    rdBurst(4, 2);
    drain(4);
    giveVerdict();
  end
endmodule
